//--- rtl/ups_dev.sv
// Purpose: Device end: gates the serial port for low-power idle.
// Assumes: Character and pending-data strobes come from the port core.
// Notes:   Short timers tick per ms, the activity timer per frame.
`timescale 1ns/1ps
// How it works
// RULE1 - Setting 0: never idle, port on, CTS on.
// RULE2 - Setting 1: port off unless cycle, transmit, wake.
// RULE3 - 2G: enable at paging after 2.0 s.
// RULE4 - 3G/LTE: 20 ms on, 2.5 s off, repeat.
// RULE5 - Unregistered: same 20 ms / 2.5 s cycle.
// RULE6 - Character holds port for configurable frame timeout.
// RULE7 - Each further character restarts the inactivity timer.
// RULE8 - Cyclic mode: CTS low when port accepts data.
// RULE9 - Setting 2 only with flow control off.
// RULE10 - Setting 2: RTS off disables, rising wakes.
// RULE11 - Setting 3: DTR off disables, rising wakes.
// RULE12 - Pending outgoing data enables port temporarily.
// RULE13 - Setting 3 any flow control; CTS shows readiness.
// RULE14 - DTR keeps its ordinary control function too.
// RULE15 - TXD rising edge while off wakes in 20 ms.
// RULE16 - Wake character discarded; recognition after wake-up.
// RULE17 - Host waits wake-up time before real characters.
// RULE18 - Data wake always active in setting 1, no flow.
// RULE19 - Host sends throwaway character before command lines.
// RULE20 - Throwaway command answered only when already active.
// RULE21 - USB stays ready regardless of power-save setting.
// RULE22 - Host disables autobaud, stores, reboots before saving.
module ups_dev
    import ups_pkg::*;
#(
    parameter int P_MS_CYC    = MS_CYC,
    parameter int P_FRAME_CYC = FRAME_CYC
) (
    // Clock and reset.
    input  wire logic          i_core_clk,
    input  wire logic          i_sys_rst,
    // Link.
    ups_link_if.dev            link,
    // Port core side.
    input  wire logic          i_char_rx,
    input  wire logic          i_tx_pending,
    // Network and USB status.
    input  wire ups_net_t      i_net,
    input  wire logic          i_paging,
    input  wire logic          i_usb_attached,
    input  wire logic          i_usb_suspended,
    // Port control outputs.
    output logic               o_port_enable,
    output logic               o_char_accept,
    output logic               o_idle,
    output logic               o_wake_discard,
    // Status outputs.
    output ups_setting_t       o_setting,
    output logic [15:0]        o_timeout,
    output logic               o_cfg_refused,
    output logic               o_dtr_on,
    output logic               o_usb_ready
);
    import ups_pkg::*;

    // Refuse divider lengths that cannot count.
    if (P_MS_CYC < 1 || P_FRAME_CYC < 1) begin : g_bad_div
        $error("Divider lengths must be at least one cycle");
    end

    ups_state_t   state;
    ups_state_t   next_state;
    ups_setting_t setting;
    logic [15:0]  timeout;
    logic [31:0]  ms_div;
    logic [31:0]  fr_div;
    logic [11:0]  ms_left;
    logic [11:0]  next_ms_left;
    logic [15:0]  fr_left;
    logic         txd_q;
    logic         rts_on_q;
    logic         dtr_on_q;
    logic         cfg_refused;

    // Line levels and edges; inputs are synchronous to the clock.
    wire rts_on   = !link.rts_n;
    wire dtr_on   = !link.dtr_n;
    wire txd_rise = link.txd && !txd_q;
    wire rts_rise = rts_on && !rts_on_q;
    wire dtr_rise = dtr_on && !dtr_on_q;
    wire ms_tick  = ms_div == 32'(P_MS_CYC - 1);
    wire fr_tick  = fr_div == 32'(P_FRAME_CYC - 1);

    // Command decode: setting 2 is refused while flow control is on.
    wire cfg_bad  = link.cfg_setting == PS_RTS_GATED && link.hw_flow;
    wire cfg_ok   = link.cfg_valid && !cfg_bad;                 // RULE9
    wire [15:0] tmo_clip =
        (link.cfg_timeout < TMO_MIN) ? TMO_MIN :
        (link.cfg_timeout > TMO_MAX) ? TMO_MAX : link.cfg_timeout;
    // Gating line of the line-controlled settings.
    wire ctl_on   = (setting == PS_RTS_GATED) ? rts_on : dtr_on;
    wire ctl_rise = (setting == PS_RTS_GATED) ? rts_rise : dtr_rise;
    // Data wake works in the cyclic setting without flow control.
    wire data_wake = setting == PS_CYCLIC && !link.hw_flow
                     && txd_rise;                               // RULE18
    wire ms_done  = ms_left == 12'h000;
    wire act_busy = fr_left != 16'h0000;
    wire [11:0] off_span = (i_net == NET_2G) ? OFF_2G_MS : OFF_3G_MS;
    // Port state right after a setting is taken.
    wire start_on = link.cfg_setting == PS_ALWAYS_ON
        || (link.cfg_setting == PS_RTS_GATED && rts_on)
        || (link.cfg_setting == PS_DTR_GATED && dtr_on);
    wire port_on  = state == ST_ON;

    // Millisecond and frame dividers for the timers.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ms_div <= '0;
            fr_div <= '0;
        end else begin
            ms_div <= ms_tick ? '0 : ms_div + 32'd1;
            fr_div <= fr_tick ? '0 : fr_div + 32'd1;
        end
    end

    // Previous line levels for edge detection.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            txd_q    <= 1'b1;
            rts_on_q <= 1'b0;
            dtr_on_q <= 1'b0;
        end else begin
            txd_q    <= link.txd;
            rts_on_q <= rts_on;
            dtr_on_q <= dtr_on;
        end
    end

    // Setting and timeout registers; setting 0 after reset.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            setting     <= PS_ALWAYS_ON;
            timeout     <= TMO_RESET;
            cfg_refused <= 1'b0;
        end else begin
            cfg_refused <= link.cfg_valid && cfg_bad;
            if (cfg_ok) begin
                setting <= link.cfg_setting;
                timeout <= tmo_clip;                            // RULE6
            end
        end
    end

    // Next state and short-timer load.
    always_comb begin
        next_state   = state;
        next_ms_left = (ms_tick && !ms_done) ? ms_left - 12'h001
                                             : ms_left;
        unique case (state)
            ST_OFF: begin
                if (i_tx_pending) begin
                    // Clear the short timer so the port drops as soon
                    // as the pending data has gone out.
                    next_state   = ST_ON;                       // RULE12
                    next_ms_left = 12'h000;
                end else if (setting == PS_ALWAYS_ON) begin
                    next_state = ST_ON;                         // RULE1
                end else if (setting == PS_CYCLIC) begin
                    if (data_wake) begin
                        next_state   = ST_WAKE;                 // RULE15
                        next_ms_left = WAKE_MS;
                    end else if (ms_done && (i_net != NET_2G
                                 || i_paging)) begin
                        next_state   = ST_ON;                   // RULE3 RULE4 RULE5
                        next_ms_left = WINDOW_MS;
                    end
                end else if (ctl_rise) begin
                    next_state   = ST_WAKE;                     // RULE10 RULE11
                    next_ms_left = WAKE_MS;
                end
            end
            ST_WAKE: begin
                if (ms_done) begin
                    next_state   = ST_ON;                       // RULE16
                    next_ms_left = 12'h000;
                end
            end
            ST_ON: begin
                if (setting == PS_CYCLIC) begin
                    if (ms_done && !act_busy && !i_tx_pending
                        && !i_char_rx) begin
                        next_state   = ST_OFF;                  // RULE4 RULE5
                        next_ms_left = off_span;
                    end
                end else if (setting != PS_ALWAYS_ON) begin
                    if (!ctl_on && !i_tx_pending) begin
                        next_state = ST_OFF;                    // RULE10 RULE11
                    end
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        if (cfg_ok) begin
            next_state   = start_on ? ST_ON : ST_OFF;           // RULE2
            next_ms_left = (link.cfg_setting == PS_CYCLIC)
                           ? off_span : 12'h000;
        end
    end

    // Port state and short timer.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state   <= ST_ON;
            ms_left <= 12'h000;
        end else begin
            state   <= next_state;
            ms_left <= next_ms_left;
        end
    end

    // Activity timer in frames: loaded on the wake-up and on each
    // recognised character, so steady traffic holds the port open.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fr_left <= 16'h0000;
        end else if (setting != PS_CYCLIC || cfg_ok) begin
            fr_left <= 16'h0000;
        end else if ((state == ST_WAKE && ms_done) || o_char_accept) begin
            fr_left <= timeout;                                 // RULE6 RULE7
        end else if (fr_tick && act_busy) begin
            fr_left <= fr_left - 16'h0001;
        end
    end

    // Characters count only while the port is on; one arriving while
    // off or waking is the wake character and is dropped.
    assign o_char_accept  = i_char_rx && port_on;               // RULE16
    assign o_wake_discard = i_char_rx && !port_on;              // RULE20
    // CTS shows whether data can be taken, in every setting and with
    // flow control on or off.
    assign link.cts_n     = !port_on;                           // RULE8 RULE13
    assign o_port_enable  = port_on;
    assign o_idle         = state == ST_OFF;
    assign o_setting      = setting;
    assign o_timeout      = timeout;
    assign o_cfg_refused  = cfg_refused;
    // DTR still feeds its ordinary handling beside the gating.
    assign o_dtr_on       = dtr_on;                             // RULE14
    // USB readiness does not depend on the power-save setting.
    assign o_usb_ready    = i_usb_attached && !i_usb_suspended; // RULE21
endmodule

//--- rtl/ups_pkg.sv
// Purpose: Shared constants and types for the serial port power-save ends.
// Assumes: One 200 MHz clock; all times are rounded to that clock.
// Notes:   Long cycle counts are defaults for module parameters.
package ups_pkg;
    // Clock period in picoseconds, so fractional periods stay exact.
    localparam int CLK_PS          = 5000;
    // One network frame of 4.615 ms, in picoseconds.
    localparam longint FRAME_PS    = 64'd4615000000;
    localparam int FRAME_CYC       = int'(FRAME_PS / CLK_PS);
    // One millisecond, the tick of all short timers.
    localparam longint MS_PS       = 64'd1000000000;
    localparam int MS_CYC          = int'(MS_PS / CLK_PS);
    // Wake-up time and short enable window, in ms.
    localparam logic [11:0] WAKE_MS    = 12'd20;
    localparam logic [11:0] WINDOW_MS  = 12'd20;
    // Disabled spans of the cyclic mode, in ms.
    localparam logic [11:0] OFF_2G_MS  = 12'd2000;
    localparam logic [11:0] OFF_3G_MS  = 12'd2500;
    // Activity timeout in frames: limits and value after reset.
    localparam logic [15:0] TMO_MIN    = 16'd40;
    localparam logic [15:0] TMO_MAX    = 16'd65000;
    localparam logic [15:0] TMO_RESET  = 16'd2000;
    // Low pulse length of the host's wake-up character, in cycles.
    localparam logic [3:0]  WAKE_LOW_CYC = 4'd8;

    // Power-save setting.
    typedef enum logic [1:0] {
        PS_ALWAYS_ON = 2'b00,
        PS_CYCLIC    = 2'b01,
        PS_RTS_GATED = 2'b10,
        PS_DTR_GATED = 2'b11
    } ups_setting_t;

    // Network the device is camped on.
    typedef enum logic [1:0] {
        NET_NONE = 2'b00,
        NET_2G   = 2'b01,
        NET_3G4G = 2'b10
    } ups_net_t;

    // Port state of the device end.
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_WAKE = 2'b01,
        ST_ON   = 2'b10
    } ups_state_t;
endpackage

//--- rtl/ups_link_if.sv
// Purpose: Serial control lines between host (DTE) and device (DCE).
// Assumes: Control lines are active low: ON is a low level.
// Notes:   Configuration travels as an abstract command strobe.
`timescale 1ns/1ps
interface ups_link_if;
    import ups_pkg::*;
    logic                txd;          // Host data line, idles high.
    logic                rts_n;        // Request to send, ON low.
    logic                dtr_n;        // Terminal ready, ON low.
    logic                cts_n;        // Clear to send, ON low.
    logic                hw_flow;      // Hardware flow control on.
    logic                cfg_valid;    // One-cycle setting command.
    ups_setting_t        cfg_setting;  // Requested setting.
    logic [15:0]         cfg_timeout;  // Activity timeout in frames.

    modport dev  (input  txd, rts_n, dtr_n, hw_flow, cfg_valid,
                  input  cfg_setting, cfg_timeout, output cts_n);
    modport host (output txd, rts_n, dtr_n, hw_flow, cfg_valid,
                  output cfg_setting, cfg_timeout, input cts_n);
endinterface

//--- rtl/ups_host.sv
// Purpose: Host end: drives control lines, wake-up character, settings.
// Assumes: User requests are synchronous single-cycle pulses or levels.
// Notes:   Holds off valid traffic for the wake-up time after a wake.
`timescale 1ns/1ps
module ups_host
    import ups_pkg::*;
#(
    parameter int P_MS_CYC = MS_CYC
) (
    // Clock and reset.
    input  wire logic          i_core_clk,
    input  wire logic          i_sys_rst,
    // Link.
    ups_link_if.host           link,
    // User side: lines and data.
    input  wire logic          i_rts_on,
    input  wire logic          i_dtr_on,
    input  wire logic          i_txd,
    input  wire logic          i_wake,
    // User side: configuration.
    input  wire logic          i_hw_flow,
    input  wire logic          i_cfg_valid,
    input  wire ups_setting_t  i_cfg_setting,
    input  wire logic [15:0]   i_cfg_timeout,
    input  wire logic          i_over_usb,
    input  wire logic          i_autobaud_off_saved,
    // User side: status.
    output logic               o_cfg_refused,
    output logic               o_wake_busy,
    output logic               o_may_send
);
    import ups_pkg::*;

    // Refuse a divider length that cannot count.
    if (P_MS_CYC < 1) begin : g_bad_ms
        $error("P_MS_CYC must be at least one");
    end

    logic [31:0] ms_div;
    logic [3:0]  low_cnt;
    logic [11:0] wait_ms;
    logic        cfg_valid;
    logic        cfg_refused;
    logic        hw_flow;

    // A request is refused when setting 2 meets flow control, or when
    // a saving setting is asked over USB before autobaud was stored off.
    wire bad_flow = i_cfg_setting == PS_RTS_GATED && i_hw_flow; // RULE9
    wire bad_usb  = i_over_usb && i_cfg_setting != PS_ALWAYS_ON
                    && !i_autobaud_off_saved;                    // RULE22
    wire ms_tick  = ms_div == 32'(P_MS_CYC - 1);
    wire wake_go  = i_wake && low_cnt == 4'h0 && wait_ms == 12'h000;

    // Millisecond divider for the wake-up hold-off.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) ms_div <= '0;
        else ms_div <= ms_tick ? '0 : ms_div + 32'd1;
    end

    // Wake character: a short low pulse whose rising edge wakes the
    // device, then a wait before any character meant to be read.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            low_cnt <= 4'h0;
            wait_ms <= 12'h000;
        end else if (wake_go) begin
            low_cnt <= WAKE_LOW_CYC;
        end else if (low_cnt != 4'h0) begin
            low_cnt <= low_cnt - 4'h1;
            if (low_cnt == 4'h1) wait_ms <= WAKE_MS + 12'd1;   // RULE17
        end else if (ms_tick && wait_ms != 12'h000) begin
            wait_ms <= wait_ms - 12'h001;
        end
    end

    // Configuration command register and flow control level.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_valid   <= 1'b0;
            cfg_refused <= 1'b0;
            hw_flow     <= 1'b0;
        end else begin
            cfg_valid   <= i_cfg_valid && !bad_flow && !bad_usb;
            cfg_refused <= i_cfg_valid && (bad_flow || bad_usb);
            hw_flow     <= i_hw_flow;
        end
    end

    // Link drive. The dummy wake character doubles as the throwaway
    // character before a command line; the device drops it only while its port is off or waking.
    assign link.txd         = (low_cnt != 4'h0) ? 1'b0 : i_txd; // RULE19
    assign link.rts_n       = !i_rts_on;
    assign link.dtr_n       = !i_dtr_on;
    assign link.hw_flow     = hw_flow;
    assign link.cfg_valid   = cfg_valid;
    assign link.cfg_setting = i_cfg_setting;
    assign link.cfg_timeout = i_cfg_timeout;
    assign o_cfg_refused    = cfg_refused;
    assign o_wake_busy      = low_cnt != 4'h0 || wait_ms != 12'h000;
    // A throwaway command that only woke the device gets no reply, so
    // real traffic waits for both the hold-off and clear to send.
    assign o_may_send = !o_wake_busy && !link.cts_n;            // RULE20
endmodule

//--- sim/ups_link_sva.sv
// Purpose: Checks the link between the host and device power-save ends.
// Assumes: Short timers run at P_MS_CYC cycles per ms.
// Notes:   Mirrors the accepted setting from the command strobe.
`timescale 1ns/1ps
module ups_link_sva
    import ups_pkg::*;
#(
    parameter int P_MS_CYC = 10
) (
    // Clock and reset.
    input  wire logic         i_core_clk,
    input  wire logic         i_sys_rst,
    // Link signals.
    input  wire logic         txd,
    input  wire logic         rts_n,
    input  wire logic         dtr_n,
    input  wire logic         cts_n,
    input  wire logic         hw_flow,
    input  wire logic         cfg_valid,
    input  wire ups_setting_t cfg_setting,
    input  wire logic [15:0]  cfg_timeout
);
    import ups_pkg::*;
    localparam int WAKE_MAX = 22 * P_MS_CYC;
    ups_setting_t set_q;
    wire logic    acc;
    wire logic    goes_off;
    wire logic    goes_on;
    // A command is taken unless it asks for RTS gating with flow on.
    assign acc = cfg_valid && !(cfg_setting == PS_RTS_GATED && hw_flow);
    assign goes_off = (cfg_setting == PS_CYCLIC)
        || (cfg_setting == PS_RTS_GATED && rts_n)
        || (cfg_setting == PS_DTR_GATED && dtr_n);
    assign goes_on = !goes_off;
    // Copy of the setting that the device holds.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            set_q <= PS_ALWAYS_ON;
        end else if (acc) begin
            set_q <= cfg_setting;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    property p_mode0_on;
        set_q == PS_ALWAYS_ON |-> !cts_n;
    endproperty
    a_mode0_on: assert property (p_mode0_on)
        else $error("CTS off while always on.");
    property p_refuse;
        cfg_valid |-> !(cfg_setting == PS_RTS_GATED && hw_flow);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("RTS gating sent with flow control on.");
    property p_cfg_off;
        acc && goes_off |=> cts_n;
    endproperty
    a_cfg_off: assert property (p_cfg_off)
        else $error("Port not disabled by new setting.");
    property p_cfg_on;
        acc && goes_on |=> !cts_n;
    endproperty
    a_cfg_on: assert property (p_cfg_on)
        else $error("Port not enabled by new setting.");
    property p_rts_wake;
        set_q == PS_RTS_GATED && $fell(rts_n) |-> ##[1:WAKE_MAX] (!cts_n || rts_n);
    endproperty
    a_rts_wake: assert property (p_rts_wake)
        else $error("RTS on did not wake the port.");
    property p_dtr_wake;
        set_q == PS_DTR_GATED && $fell(dtr_n) |-> ##[1:WAKE_MAX] (!cts_n || dtr_n);
    endproperty
    a_dtr_wake: assert property (p_dtr_wake)
        else $error("DTR on did not wake the port.");
    property p_txd_wake;
        set_q == PS_CYCLIC && !hw_flow && cts_n && $rose(txd)
            |-> ##[1:WAKE_MAX] !cts_n;
    endproperty
    a_txd_wake: assert property (p_txd_wake)
        else $error("Data wake did not enable the port.");
    property p_wake_hold;
        set_q == PS_CYCLIC && !hw_flow && cts_n && $rose(txd) |=> cts_n [*8];
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("Port enabled before wake-up time.");
    property p_host_pulse;
        $fell(txd) |-> !txd [*8] ##1 txd;
    endproperty
    a_host_pulse: assert property (p_host_pulse)
        else $error("Wake character has wrong length.");
endmodule

//--- sim/tb_uart_power_save_gating.sv
// Purpose: Drives host and device ends through every power-save setting.
// Assumes: Timers scaled to 10 cycles a ms and 20 cycles a frame.
// Notes:   Host data line is tied; checks use CTS timing.
`timescale 1ns/1ps
module tb_uart_power_save_gating;
    import ups_pkg::*;
    localparam int MSC = 10;
    localparam int FRC = 20;
    logic clk, rst, rts_on, dtr_on, wake, hw_flow, cfg_v, over_usb, saved;
    logic char_rx, tx_pend, usb_susp, h_ref, busy, may_send, ref_seen;
    logic pen, acc_o, idle, disc, d_ref, dtr_o, usb_rdy, paging, usb_att;
    ups_setting_t cfg_set, d_set;
    ups_net_t     net;
    logic [15:0]  cfg_tmo, d_tmo;
    int           bad_count, compares, cycles, n;
    ups_link_if link();
    ups_host #(.P_MS_CYC(MSC)) i_ups_host (.i_core_clk(clk),
        .i_sys_rst(rst), .link(link), .i_rts_on(rts_on), .i_dtr_on(dtr_on),
        .i_txd(1'b1), .i_wake(wake), .i_hw_flow(hw_flow), .i_cfg_valid(cfg_v),
        .i_cfg_setting(cfg_set), .i_cfg_timeout(cfg_tmo),
        .i_over_usb(over_usb), .i_autobaud_off_saved(saved),
        .o_cfg_refused(h_ref), .o_wake_busy(busy), .o_may_send(may_send));
    ups_dev #(.P_MS_CYC(MSC), .P_FRAME_CYC(FRC)) i_ups_dev (.i_core_clk(clk),
        .i_sys_rst(rst), .link(link), .i_char_rx(char_rx),
        .i_tx_pending(tx_pend), .i_net(net), .i_paging(paging),
        .i_usb_attached(usb_att), .i_usb_suspended(usb_susp),
        .o_port_enable(pen), .o_char_accept(acc_o), .o_idle(idle),
        .o_wake_discard(disc), .o_setting(d_set), .o_timeout(d_tmo),
        .o_cfg_refused(d_ref), .o_dtr_on(dtr_o), .o_usb_ready(usb_rdy));
    ups_link_sva #(.P_MS_CYC(MSC)) i_ups_link_sva (.i_core_clk(clk),
        .i_sys_rst(rst), .txd(link.txd), .rts_n(link.rts_n),
        .dtr_n(link.dtr_n), .cts_n(link.cts_n), .hw_flow(link.hw_flow),
        .cfg_valid(link.cfg_valid), .cfg_setting(link.cfg_setting),
        .cfg_timeout(link.cfg_timeout));
    // Reports the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Compares one flag.
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compares a setting or timeout word.
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compares a measured cycle count against a window.
    task automatic chk_range(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    // Waits a number of cycles, then lets the edge settle.
    task automatic wait_n(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Counts cycles until CTS shows the wanted level, up to a limit.
    task automatic wait_cts(input logic exp, input int lim);
        n = 0;
        while (link.cts_n !== exp && n < lim) begin
            wait_n(1);
            n++;
        end
    endtask
    // Sends a setting command and waits until the device has taken it.
    task automatic cfg(input ups_setting_t s, input logic [15:0] t,
                       input logic f);
        @(posedge clk);
        cfg_v <= 1'b1;
        cfg_set <= s;
        cfg_tmo <= t;
        hw_flow <= f;
        @(posedge clk);
        cfg_v <= 1'b0;
        #1 ref_seen = h_ref;
        wait_n(1);
    endtask
    // Hands one decoded character to the device and checks its fate.
    task automatic char_pulse(input logic exp);
        @(posedge clk);
        char_rx <= 1'b1;
        #1 chk_bit(acc_o, exp);
        chk_bit(disc, !exp);
        @(posedge clk);
        char_rx <= 1'b0;
        #1;
    endtask
    // Free-running clock of 5 ns.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            bad_count++;
            finish_test();
        end
    end
    // Main sequence.
    initial begin
        {rst, rts_on, dtr_on, wake, hw_flow, cfg_v, usb_att} = 7'h41;
        {over_usb, saved, char_rx, tx_pend, usb_susp, paging} = 6'h00;
        cfg_set = PS_ALWAYS_ON;
        cfg_tmo = 16'h07d0;
        net = NET_3G4G;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wait_n(1);
        chk_bit(link.cts_n, 1'b0);
        chk_word(d_tmo, 16'h07d0);
        chk_bit(usb_rdy, 1'b1);
        cfg(PS_RTS_GATED, 16'h07d0, 1'b1);
        chk_bit(ref_seen, 1'b1);
        chk_bit(d_ref, 1'b0);
        chk_word({14'h0000, d_set}, 16'h0000);
        over_usb <= 1'b1;
        cfg(PS_CYCLIC, 16'h07d0, 1'b0);
        chk_bit(ref_seen, 1'b1);
        saved <= 1'b1;
        cfg(PS_CYCLIC, 16'h000a, 1'b0);
        chk_word({14'h0000, d_set}, 16'h0001);
        chk_word(d_tmo, 16'h0028);
        chk_bit(link.cts_n, 1'b1);
        chk_bit(idle, 1'b1);
        chk_bit(usb_rdy, 1'b1);
        char_pulse(1'b0);
        tx_pend <= 1'b1;
        wait_n(2);
        chk_bit(link.cts_n, 1'b0);
        chk_bit(pen, 1'b1);
        tx_pend <= 1'b0;
        wait_cts(1'b1, 1000);
        chk_range(n, 0, 999);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1 chk_bit(busy, 1'b1);
        wait_cts(1'b0, 400);
        chk_range(n, 200, 225);
        wait_n(30);
        chk_bit(may_send, 1'b1);
        chk_bit(busy, 1'b0);
        char_pulse(1'b1);
        repeat (3) begin
            wait_n(600);
            chk_bit(link.cts_n, 1'b0);
            char_pulse(1'b1);
        end
        wait_cts(1'b1, 1200);
        chk_range(n, 770, 830);
        wait_cts(1'b0, 26000);
        chk_range(n, 24980, 25020);
        wait_cts(1'b1, 400);
        chk_range(n, 190, 215);
        net <= NET_NONE;
        wait_cts(1'b0, 26000);
        chk_range(n, 24980, 25020);
        // On 2G the port stays off past the span until a paging slot.
        net <= NET_2G;
        wait_cts(1'b1, 400);
        wait_n(20100);
        chk_bit(link.cts_n, 1'b1);
        paging <= 1'b1;
        wait_n(1);
        paging <= 1'b0;
        chk_bit(link.cts_n, 1'b0);
        cfg(PS_RTS_GATED, 16'h07d0, 1'b0);
        chk_bit(link.cts_n, 1'b1);
        rts_on <= 1'b1;
        wait_cts(1'b0, 400);
        chk_range(n, 190, 215);
        rts_on <= 1'b0;
        wait_n(3);
        chk_bit(link.cts_n, 1'b1);
        cfg(PS_DTR_GATED, 16'hffff, 1'b1);
        chk_word(d_tmo, 16'hfde8);
        chk_bit(link.cts_n, 1'b1);
        dtr_on <= 1'b1;
        wait_cts(1'b0, 400);
        chk_range(n, 190, 215);
        chk_bit(dtr_o, 1'b1);
        cfg(PS_ALWAYS_ON, 16'h07d0, 1'b0);
        chk_bit(link.cts_n, 1'b0);
        usb_susp <= 1'b1;
        wait_n(1);
        chk_bit(usb_rdy, 1'b0);
        usb_att <= 1'b0;
        usb_susp <= 1'b0;
        wait_n(1);
        chk_bit(usb_rdy, 1'b0);
        finish_test();
    end
endmodule
